// ### pkg/cssh_defines.svh
`ifndef CSSH_DEFINES_SVH
`define CSSH_DEFINES_SVH

// Register indices; byte address is four times the index
`define CSSH_IDX_H2_START      7'h5c
`define CSSH_IDX_H2_STOP       7'h5d
`define CSSH_IDX_V2_START      7'h5e
`define CSSH_IDX_V2_STOP       7'h5f
`define CSSH_IDX_COMB2         7'h60
`define CSSH_IDX_H3_START      7'h61
`define CSSH_IDX_H3_STOP       7'h62

// Field positions in the combiner register
`define CSSH_COMB_XOR_BIT      0
`define CSSH_COMB_OR_BIT       1
`define CSSH_COMB_AND_BIT      2
`define CSSH_COMB_POL_BIT      3

// Reset values
`define CSSH_RST_HPIX          16'h0000
`define CSSH_RST_VLINE         15'h0000
`define CSSH_RST_COMB          4'h8

// Field widths
`define CSSH_HPIX_W            16
`define CSSH_VLINE_W           15
`define CSSH_COMB_W            4

`endif

// ### pkg/cssh_pkg.sv
`default_nettype none

package cssh_pkg;

    // Software-visible configuration of the shaper
    typedef struct packed {
        logic [15:0] h2_start;  // Second signal horizontal start
        logic [15:0] h2_stop;   // Second signal horizontal stop
        logic [14:0] v2_start;  // Second signal start line
        logic [14:0] v2_stop;   // Second signal stop line
        logic [3:0]  comb2;     // Polarity, AND, OR, XOR
        logic [15:0] h3_start;  // Third signal horizontal start
        logic [15:0] h3_stop;   // Third signal horizontal stop
    } cssh_regs_t;

    // Whole state of the top module
    typedef struct packed {
        cssh_regs_t  regs;      // Configuration
        logic        ack;       // Bus acknowledge
        logic [31:0] dat;       // Bus read data
        logic        out2;      // Final second output pin level
        logic        out3;      // Third horizontal pulse
    } cssh_state_t;

    // State of one span comparator
    typedef struct packed {
        logic active;           // Component active
    } cssh_span_st_t;

    // Combine two components through the operator bits, AND first, then OR, then XOR
    function automatic logic cssh_combine(input logic h, input logic v,
                                          input logic [3:0] op);
        logic res;
        res = 1'b0;
        if (op[2])
            res = h & v;
        else if (op[1])
            res = h | v;
        else if (op[0])
            res = h ^ v;
        return res;
    endfunction : cssh_combine

    // Apply polarity: bit set gives an active-low pin
    function automatic logic cssh_drive(input logic comb, input logic pol);
        return pol ? ~comb : comb;
    endfunction : cssh_drive

endpackage : cssh_pkg

`default_nettype wire

// ### core/cssh_span.sv
`timescale 1ns/1ps
`default_nettype none

// Registered window comparator: active from start up to, not including, stop
module cssh_span
    import cssh_pkg::*;
#(
    parameter int W = 16        // Counter width
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] start,
    input  wire logic [W-1:0] stop,
    output logic              active
);

    cssh_span_st_t s_r;         // Registered state
    cssh_span_st_t s_nxt;       // Next state

    // Compare every cycle; a start not below stop never opens
    always_comb begin
        s_nxt = s_r;
        s_nxt.active = (count >= start) && (count < stop);
    end

    // Register the comparison to keep the pin path short
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign active = s_r.active;

endmodule : cssh_span

`default_nettype wire

// ### core/cssh_shaper.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssh_defines.svh"

// Custom sync shaper with a classic Wishbone register slave
module cssh_shaper
    import cssh_pkg::*;
#(
    parameter int HW = `CSSH_HPIX_W,   // Pixel counter width
    parameter int VW = `CSSH_VLINE_W   // Line counter width
) (
    input  wire logic          mclk,
    input  wire logic          arst_n,
    // Timing counters of the output video
    input  wire logic [HW-1:0] pixel_count,
    input  wire logic [VW-1:0] line_count,
    // Wishbone classic slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [8:0]    wb_adr_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    // Shaped outputs
    output logic               second_custom_output,
    output logic               third_custom_horizontal_pulse
);

    cssh_state_t s_r;           // Registered state
    cssh_state_t s_nxt;         // Next state

    logic second_custom_horizontal_pulse;  // Horizontal component
    logic second_custom_vertical_pulse;    // Vertical component
    logic h3_act;                          // Third horizontal component
    logic bus_req;                         // New bus request this cycle
    logic [6:0] reg_idx;                   // Word index of access

    assign bus_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign reg_idx = wb_adr_i[8:2];

    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
            res[7:0] = wd[7:0];
        if (sel[1])
            res[15:8] = wd[15:8];
        return res;
    endfunction : lane_merge

    // Read view of a register; reserved bits read as zero
    function automatic logic [31:0] reg_read(input cssh_regs_t r,
                                             input logic [6:0] idx);
        logic [31:0] res;
        res = 32'h0000_0000;
        unique case (idx)
            `CSSH_IDX_H2_START: res = {16'h0000, r.h2_start};
            `CSSH_IDX_H2_STOP:  res = {16'h0000, r.h2_stop};
            `CSSH_IDX_V2_START: res = {17'h0_0000, r.v2_start};
            `CSSH_IDX_V2_STOP:  res = {17'h0_0000, r.v2_stop};
            `CSSH_IDX_COMB2:    res = {28'h000_0000, r.comb2};
            `CSSH_IDX_H3_START: res = {16'h0000, r.h3_start};
            `CSSH_IDX_H3_STOP:  res = {16'h0000, r.h3_stop};
            // Unmapped word reads zero and is still acknowledged
            default:            res = 32'h0000_0000;
        endcase
        return res;
    endfunction : reg_read

    // Second signal horizontal component, per-line pixel compare
    cssh_span #(.W(HW)) u_h2 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .count  (pixel_count),
        .start  (s_r.regs.h2_start),
        .stop   (s_r.regs.h2_stop),
        .active (second_custom_horizontal_pulse)
    );

    // Second signal vertical component; line_count is odd-field numbered
    cssh_span #(.W(VW)) u_v2 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .count  (line_count),
        .start  (s_r.regs.v2_start),
        .stop   (s_r.regs.v2_stop),
        .active (second_custom_vertical_pulse)
    );

    // Third signal horizontal component
    cssh_span #(.W(HW)) u_h3 (
        .mclk   (mclk),
        .arst_n (arst_n),
        .count  (pixel_count),
        .start  (s_r.regs.h3_start),
        .stop   (s_r.regs.h3_stop),
        .active (h3_act)
    );

    // Next-state logic: bus slave and output shaping
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        // One ack per request; ack drops in the following cycle
        if (bus_req) begin
            s_nxt.ack = 1'b1;
            s_nxt.dat = reg_read(s_r.regs, reg_idx);
            if (wb_we_i) begin
                unique case (reg_idx)
                    `CSSH_IDX_H2_START:
                        s_nxt.regs.h2_start = lane_merge(s_r.regs.h2_start, wb_dat_i, wb_sel_i);
                    `CSSH_IDX_H2_STOP:
                        s_nxt.regs.h2_stop = lane_merge(s_r.regs.h2_stop, wb_dat_i, wb_sel_i);
                    // Top bit is reserved, so only 15 bits are kept
                    `CSSH_IDX_V2_START:
                        s_nxt.regs.v2_start = 15'(lane_merge({1'b0, s_r.regs.v2_start},
                                                             wb_dat_i, wb_sel_i) & 16'h7fff);
                    `CSSH_IDX_V2_STOP:
                        s_nxt.regs.v2_stop = 15'(lane_merge({1'b0, s_r.regs.v2_stop},
                                                            wb_dat_i, wb_sel_i) & 16'h7fff);
                    // Upper twelve bits are reserved and dropped
                    `CSSH_IDX_COMB2:
                        if (wb_sel_i[0])
                            s_nxt.regs.comb2 = wb_dat_i[3:0];
                    `CSSH_IDX_H3_START:
                        s_nxt.regs.h3_start = lane_merge(s_r.regs.h3_start, wb_dat_i, wb_sel_i);
                    `CSSH_IDX_H3_STOP:
                        s_nxt.regs.h3_stop = lane_merge(s_r.regs.h3_stop, wb_dat_i, wb_sel_i);
                    // Writes to unmapped words are ignored
                    default: ;
                endcase
            end
        end
        // AND beats OR beats XOR; no bit set keeps the signal inactive
        s_nxt.out2 = cssh_drive(
            cssh_combine(second_custom_horizontal_pulse,
                         second_custom_vertical_pulse,
                         s_r.regs.comb2),
            s_r.regs.comb2[`CSSH_COMB_POL_BIT]);
        // Third signal combiner lives elsewhere; pulse goes out active high
        s_nxt.out3 = h3_act;
    end

    // State register; inactive pin level is high under default polarity
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r.regs.h2_start <= `CSSH_RST_HPIX;
            s_r.regs.h2_stop  <= `CSSH_RST_HPIX;
            s_r.regs.v2_start <= `CSSH_RST_VLINE;
            s_r.regs.v2_stop  <= `CSSH_RST_VLINE;
            s_r.regs.comb2    <= `CSSH_RST_COMB;
            s_r.regs.h3_start <= `CSSH_RST_HPIX;
            s_r.regs.h3_stop  <= `CSSH_RST_HPIX;
            s_r.ack           <= 1'b0;
            s_r.dat           <= 32'h0000_0000;
            s_r.out2          <= 1'b1;
            s_r.out3          <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o                      = s_r.dat;
    assign wb_ack_o                      = s_r.ack;
    assign second_custom_output          = s_r.out2;
    assign third_custom_horizontal_pulse = s_r.out3;

    // Checks next to the logic they guard
    logic [1:0] comp2;          // Both components of the second signal
    assign comp2 = {second_custom_horizontal_pulse, second_custom_vertical_pulse};

    // A write to the stop-line word is acked next cycle and visible in that same cycle
    sequence s_stop_write;
        bus_req && wb_we_i && (reg_idx == `CSSH_IDX_V2_STOP) && (wb_sel_i[1:0] == 2'b11);
    endsequence

    sequence s_stop_taken;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_stop_wr;
        @(posedge mclk) disable iff (!arst_n)
        s_stop_write |=> s_stop_taken and (1'b1 ##0 (s_r.regs.v2_stop == $past(wb_dat_i[14:0])));
    endproperty
    a_stop_wr: assert property (p_stop_wr) else $error("stop line write lost");

    property p_vstop;
        @(posedge mclk) disable iff (!arst_n)
        (line_count == s_r.regs.v2_stop) |=> !second_custom_vertical_pulse;
    endproperty
    a_vstop: assert property (p_vstop) else $error("vertical pulse past stop line");

    property p_vstart;
        @(posedge mclk) disable iff (!arst_n)
        (line_count == s_r.regs.v2_start) && (s_r.regs.v2_start < s_r.regs.v2_stop)
            |=> second_custom_vertical_pulse;
    endproperty
    a_vstart: assert property (p_vstart) else $error("vertical pulse missed start");

    property p_h3start;
        @(posedge mclk) disable iff (!arst_n)
        (pixel_count == s_r.regs.h3_start) && (s_r.regs.h3_start < s_r.regs.h3_stop)
            |=> h3_act ##1 third_custom_horizontal_pulse;
    endproperty
    a_h3start: assert property (p_h3start) else $error("third pulse missed start");

    property p_h3stop;
        @(posedge mclk) disable iff (!arst_n)
        (pixel_count == s_r.regs.h3_stop) |=> ##1 !third_custom_horizontal_pulse;
    endproperty
    a_h3stop: assert property (p_h3stop) else $error("third pulse past stop");

    property p_h2win;
        @(posedge mclk) disable iff (!arst_n)
        (pixel_count >= s_r.regs.h2_start) && (pixel_count < s_r.regs.h2_stop)
            |=> second_custom_horizontal_pulse;
    endproperty
    a_h2win: assert property (p_h2win) else $error("horizontal window not active");

    property p_and;
        @(posedge mclk) disable iff (!arst_n)
        s_r.regs.comb2[`CSSH_COMB_AND_BIT]
            |=> second_custom_output == ($past(s_r.regs.comb2[3]) ^ ($past(comp2) == 2'b11));
    endproperty
    a_and: assert property (p_and) else $error("AND combine wrong");

    property p_or;
        @(posedge mclk) disable iff (!arst_n)
        s_r.regs.comb2[2:1] == 2'b01
            |=> second_custom_output == ($past(s_r.regs.comb2[3]) ^ ($past(comp2) != 2'b00));
    endproperty
    a_or: assert property (p_or) else $error("OR combine wrong");

    property p_xor;
        @(posedge mclk) disable iff (!arst_n)
        s_r.regs.comb2[2:0] == 3'b001
            |=> second_custom_output == ($past(s_r.regs.comb2[3]) ^ ^$past(comp2));
    endproperty
    a_xor: assert property (p_xor) else $error("XOR combine wrong");

    property p_pol;
        @(posedge mclk) disable iff (!arst_n)
        (s_r.regs.comb2[2:0] == 3'b000) |=> second_custom_output == $past(s_r.regs.comb2[3]);
    endproperty
    a_pol: assert property (p_pol) else $error("idle level ignores polarity");

    // Every taken request gets exactly one ack pulse
    property p_ack_once;
        @(posedge mclk) disable iff (!arst_n)
        bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack not a single pulse");

    // No cycle on the bus, no ack in the next cycle
    property p_ack_idle;
        @(posedge mclk) disable iff (!arst_n)
        !wb_cyc_i |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without a bus cycle");

    // Register view at the current index, for the read check
    logic [31:0] rd_view;       // Read view before registering
    assign rd_view = reg_read(s_r.regs, reg_idx);

    property p_rd_data;
        @(posedge mclk) disable iff (!arst_n)
        bus_req && !wb_we_i |=> wb_dat_o == $past(rd_view);
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not the register view");

    // Combiner writes take the low lane only
    property p_comb_wr;
        @(posedge mclk) disable iff (!arst_n)
        bus_req && wb_we_i && (reg_idx == `CSSH_IDX_COMB2) && wb_sel_i[0]
            |=> s_r.regs.comb2 == $past(wb_dat_i[3:0]);
    endproperty
    a_comb_wr: assert property (p_comb_wr) else $error("combiner write lost");

    // Reserved top bit of the stop line never reads back
    property p_line_rd;
        @(posedge mclk) disable iff (!arst_n)
        bus_req && (reg_idx == `CSSH_IDX_V2_STOP) |=> wb_dat_o[31:15] == 17'h0_0000;
    endproperty
    a_line_rd: assert property (p_line_rd) else $error("stop line upper bits set");

    // Whole third window shows on the pin two edges later
    property p_h3win;
        @(posedge mclk) disable iff (!arst_n)
        (pixel_count >= s_r.regs.h3_start) && (pixel_count < s_r.regs.h3_stop)
            |=> ##1 third_custom_horizontal_pulse;
    endproperty
    a_h3win: assert property (p_h3win) else $error("third window not active");

    // Whole vertical window drives the component one edge later
    property p_v2win;
        @(posedge mclk) disable iff (!arst_n)
        (line_count >= s_r.regs.v2_start) && (line_count < s_r.regs.v2_stop)
            |=> second_custom_vertical_pulse;
    endproperty
    a_v2win: assert property (p_v2win) else $error("vertical window not active");

endmodule : cssh_shaper

`default_nettype wire

// ### testbench/cssh_shaper_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cssh_defines.svh"

// Self-checking bench for the custom sync shaper
module cssh_shaper_tb;
    import cssh_pkg::*;

    logic        mclk;              // 200 MHz clock
    logic        arst_n;            // Async reset, active low
    logic [15:0] pixel_count;       // Pixel within line
    logic [14:0] line_count;        // Line within field
    logic        wb_cyc;            // Bus cycle
    logic        wb_stb;            // Bus strobe
    logic        wb_we;             // Write enable
    logic [3:0]  wb_sel;            // Byte lanes
    logic [8:0]  wb_adr;            // Byte address
    logic [31:0] wb_dat_w;          // Write data
    logic [31:0] wb_dat_r;          // Read data
    logic        wb_ack;            // Acknowledge
    logic        out2;              // Second output pin
    logic        out3;              // Third horizontal pulse
    int          errors;            // Mismatch count
    int          samples_checked;   // Comparison count

    cssh_shaper dut (
        .mclk                          (mclk),
        .arst_n                        (arst_n),
        .pixel_count                   (pixel_count),
        .line_count                    (line_count),
        .wb_cyc_i                      (wb_cyc),
        .wb_stb_i                      (wb_stb),
        .wb_we_i                       (wb_we),
        .wb_sel_i                      (wb_sel),
        .wb_adr_i                      (wb_adr),
        .wb_dat_i                      (wb_dat_w),
        .wb_dat_o                      (wb_dat_r),
        .wb_ack_o                      (wb_ack),
        .second_custom_output          (out2),
        .third_custom_horizontal_pulse (out3)
    );

    // Free-running clock
    always #2.5 mclk = ~mclk;

    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic cycle; waits for ack without assuming its latency
    task automatic wb_xfer(input logic we, input logic [6:0] idx, input logic [3:0] sel,
                           input logic [15:0] wd, output logic [31:0] rd);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_sel   <= sel;
        wb_adr   <= {idx, 2'b00};
        wb_dat_w <= {16'h0000, wd};
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        // Idle gap so the slave sees the request drop
        @(posedge mclk);
        check("bus ack drop", 32'h0000_0000, {31'h0000_0000, wb_ack});
    endtask : wb_xfer

    // Write a full register, then read it back against the stored value
    task automatic wr_rd(input logic [6:0] idx, input logic [15:0] wd, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b1, idx, 4'h3, wd, rd);
        wb_xfer(1'b0, idx, 4'h3, 16'h0000, rd);
        check("register readback", exp, rd);
    endtask : wr_rd

    // Hold counters, let the two-stage path settle, compare both pins
    task automatic video(input logic [15:0] p, input logic [14:0] l, input logic e2,
                         input logic e3);
        pixel_count <= p;
        line_count  <= l;
        repeat (3) @(posedge mclk);
        check("second output", {31'h0000_0000, e2}, {31'h0000_0000, out2});
        check("third pulse", {31'h0000_0000, e3}, {31'h0000_0000, out3});
    endtask : video

    // Reset values and unmapped place
    task automatic t_reset_regs;
        logic [31:0] rd;
        check("pin after reset", 32'h0000_0001, {31'h0000_0000, out2});
        wb_xfer(1'b0, `CSSH_IDX_V2_STOP, 4'h3, 16'h0000, rd);
        check("stop line reset", 32'h0000_0000, rd);
        wb_xfer(1'b0, `CSSH_IDX_COMB2, 4'h3, 16'h0000, rd);
        check("combiner reset", 32'h0000_0008, rd);
        wb_xfer(1'b0, `CSSH_IDX_H3_START, 4'h3, 16'h0000, rd);
        check("h3 start reset", 32'h0000_0000, rd);
        wb_xfer(1'b0, `CSSH_IDX_H3_STOP, 4'h3, 16'h0000, rd);
        check("h3 stop reset", 32'h0000_0000, rd);
        wr_rd(7'h70, 16'hffff, 32'h0000_0000);
        // Low lane only: upper byte must keep its old value
        wr_rd(`CSSH_IDX_H3_START, 16'h1234, 32'h0000_1234);
        wb_xfer(1'b1, `CSSH_IDX_H3_START, 4'h1, 16'hab56, rd);
        wb_xfer(1'b0, `CSSH_IDX_H3_START, 4'h3, 16'h0000, rd);
        check("lane write", 32'h0000_1256, rd);
    endtask : t_reset_regs

    // Third horizontal pulse window, both edges
    task automatic t_third;
        wr_rd(`CSSH_IDX_H3_START, 16'h0010, 32'h0000_0010);
        wr_rd(`CSSH_IDX_H3_STOP, 16'h0014, 32'h0000_0014);
        for (int p = 14; p <= 22; p++) begin
            video(p[15:0], 15'h0000, 1'b1, p >= 16 && p < 20);
        end
    endtask : t_third

    // Second signal window edges through the OR operator, active high
    task automatic t_second_edges;
        wr_rd(`CSSH_IDX_H2_START, 16'h000a, 32'h0000_000a);
        wr_rd(`CSSH_IDX_H2_STOP, 16'h0014, 32'h0000_0014);
        wr_rd(`CSSH_IDX_V2_START, 16'h0005, 32'h0000_0005);
        wr_rd(`CSSH_IDX_V2_STOP, 16'h0008, 32'h0000_0008);
        wr_rd(`CSSH_IDX_COMB2, 16'h0002, 32'h0000_0002);
        for (int l = 4; l <= 9; l++) begin
            video(16'h0000, l[14:0], l >= 5 && l < 8, 1'b0);
        end
        video(16'h0009, 15'h0000, 1'b0, 1'b0);
        video(16'h000a, 15'h0000, 1'b1, 1'b0);
        video(16'h0013, 15'h0000, 1'b1, 1'b1);
        video(16'h0014, 15'h0000, 1'b0, 1'b0);
    endtask : t_second_edges

    // Every operator and polarity code against every component pair
    task automatic t_combiner;
        logic h;
        logic v;
        logic act;
        for (int op = 0; op < 16; op++) begin
            wr_rd(`CSSH_IDX_COMB2, op[15:0], op);
            for (int hv = 0; hv < 4; hv++) begin
                h = hv[1];
                v = hv[0];
                // Priority: AND over OR over XOR, none gives inactive
                if (op[2]) act = h && v;
                else if (op[1]) act = h || v;
                else if (op[0]) act = h != v;
                else act = 1'b0;
                video(h ? 16'h000f : 16'h0019, v ? 15'h0006 : 15'h000a,
                      op[3] ? !act : act, 1'b0);
            end
        end
    endtask : t_combiner

    // Reset in mid-run returns registers and pin to their idle values
    task automatic t_mid_reset;
        logic [31:0] rd;
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check("pin in reset", 32'h0000_0001, {31'h0000_0000, out2});
        arst_n <= 1'b1;
        @(posedge mclk);
        wb_xfer(1'b0, `CSSH_IDX_COMB2, 4'h3, 16'h0000, rd);
        check("combiner after reset", 32'h0000_0008, rd);
        wb_xfer(1'b0, `CSSH_IDX_V2_STOP, 4'h3, 16'h0000, rd);
        check("stop line after reset", 32'h0000_0000, rd);
    endtask : t_mid_reset

    // Counts, verdict and end of run
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        pixel_count = 16'h0000;
        line_count = 15'h0000;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_sel = 4'h0;
        wb_adr = 9'h000;
        wb_dat_w = 32'h0000_0000;
        errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_reset_regs();
        t_third();
        t_second_edges();
        t_combiner();
        t_mid_reset();
        print_verdict();
    end

    // Whole run is under 3000 cycles; a hang ends it here
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        print_verdict();
    end

endmodule : cssh_shaper_tb
`default_nettype wire
